// File: core/bws_regs.svh
`ifndef BWS_REGS_SVH
`define BWS_REGS_SVH
// Functional notes
// - silence timeout flag (bit 4) sets only while selective wake is enabled
// - timeout flag sets with bus-silent indication and stays set afterwards
// - timeout flag raises interrupt in Stop/Normal when its mask bit is 1
// - clears of the timeout flag are ignored until next irq falling edge
// - system error flag (bit 3) sets on config error or frame errors above 32
// - system error sets only while enabled; when set, enabling is refused
// - system error 0 means selective wake possible, 1 blocks enabling
// - fault field bits 2:1: 00 none, 01 thermal, 10 tx dominant, 11 bus dominant
// - bit 0 flags supply low, disables transmitter; comparator on in Normal/Rx only
// - tx dominant fault recovers on tx data high or transceiver wake/off
// - bus dominant fault recovers on recessive bus or transceiver wake/off
// - supply low recovers as soon as supply is above threshold again
// - after any recovery, tx data must stay high for enable time first
// - wake flags: bus bit 9, timer two bit 8, timer one bit 7, inputs bits 4:0
// - entering Fail-Safe clears the whole wake flag register by itself
// - level register shows five wake inputs in bits 4:0, 1 high, 0 low
// - level register refreshes continuously in Normal, Stop, Init and Restart
// - in cyclic sense or wake, levels update after each sampling instant
// - reserved bits of these registers always read as zero
// - flags clear by host clear command over the serial port or soft reset; wake flags also at Fail-Safe entry, input wake bits 0 and 2-4 also at restart
`define BWS_ADDR_BUS        7'h43
`define BWS_ADDR_WAKE       7'h44
`define BWS_ADDR_LEVEL      7'h45
`define BWS_BUS_RESET       16'h0000
`define BWS_WAKE_RESET      16'h0000
`define BWS_LEVEL_RESET     16'h0000
`define BWS_WAKE_IMPL       16'h039f
`define BWS_WAKE_KEEP       16'h0782
`define BWS_WAKE_BUS_BIT    9
`define BWS_WAKE_T2_BIT     8
`define BWS_WAKE_T1_BIT     7
`define BWS_BUS_TO_BIT      4
`define BWS_BUS_SELECTIVE_WAKE_SYS_ERROR_BIT  3
`define BWS_BUS_FAULT_LSB   1
`define BWS_BUS_UV_BIT      0
`define BWS_FAULT_NONE      2'h0
`define BWS_FAULT_THERMAL   2'h1
`define BWS_FAULT_TXD_DOM   2'h2
`define BWS_FAULT_BUS_DOM   2'h3
`define BWS_FRAME_ERR_LIMIT 6'h20
`define BWS_FRAME_BITS      5'h18
`define BWS_CMD_BITS        5'h08
`define BWS_CLK_PERIOD_NS   10
`define BWS_TX_EN_TIME_NS   4000
`define BWS_TX_EN_CYC ((`BWS_TX_EN_TIME_NS + `BWS_CLK_PERIOD_NS - 1) / `BWS_CLK_PERIOD_NS)
`define BWS_IRQ_PULSE_NS    1000
`define BWS_IRQ_PULSE_CYC ((`BWS_IRQ_PULSE_NS + `BWS_CLK_PERIOD_NS - 1) / `BWS_CLK_PERIOD_NS)
`endif

// File: core/bws_pkg.sv
package bws_pkg;
  typedef enum logic [2:0] {
    BWS_M_INIT, BWS_M_NORMAL, BWS_M_STOP, BWS_M_SLEEP, BWS_M_RESTART, BWS_M_FAIL_SAFE
  } bws_dev_mode_t;
  typedef enum logic [1:0] {
    BWS_T_OFF, BWS_T_WAKE_CAPABLE, BWS_T_RX_ONLY, BWS_T_NORMAL
  } bws_trx_mode_t;
  typedef enum {BWS_F_IDLE, BWS_F_CMD, BWS_F_DATA} bws_frame_state_t;
endpackage

// File: core/bws_spi_if.sv
`timescale 1ns/1ps
interface bws_spi_if;
  logic [6:0]  addr;
  logic        clr;
  logic        addr_valid;
  logic        frame_done;
  logic [15:0] rd_data;
  modport frame (output addr, clr, addr_valid, frame_done, input rd_data);
  modport regs (input addr, clr, addr_valid, frame_done, output rd_data);
endinterface

// File: core/bws_spi_frame.sv
`timescale 1ns/1ps
`include "bws_regs.svh"
module bws_spi_frame (
  // clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst_b,
  // serial pins
  input  wire logic  i_spi_sclk,
  input  wire logic  i_spi_csn_b,
  input  wire logic  i_spi_mosi,
  output logic       o_spi_miso,
  output logic       o_spi_miso_oe,
  // register side
  bws_spi_if.frame   spi
);
  logic [2:0]                  sclk_q;
  logic [2:0]                  csn_q;
  logic [1:0]                  mosi_q;
  logic [4:0]                  cnt;
  logic [7:0]                  sh_in;
  logic [15:0]                 sh_out;
  logic                        load_q;
  logic                        addr_valid_q;
  logic                        done_q;
  bws_pkg::bws_frame_state_t   state;

  // pins are asynchronous; stage two and three only feed the edge detectors
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q <= 3'h0;
      csn_q  <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_spi_sclk};
      csn_q  <= {csn_q[1:0], i_spi_csn_b};
      mosi_q <= {mosi_q[0], i_spi_mosi};
    end
  end

  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];
  wire csn_fall  = ~csn_q[1] & csn_q[2];
  wire csn_rise  = csn_q[1] & ~csn_q[2];
  wire last_cmd  = (cnt == `BWS_CMD_BITS - 5'h01);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state        <= bws_pkg::BWS_F_IDLE;
      cnt          <= 5'h00;
      sh_in        <= 8'h00;
      sh_out       <= 16'h0000;
      load_q       <= 1'b0;
      addr_valid_q <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      addr_valid_q <= 1'b0;
      done_q       <= 1'b0;
      load_q       <= addr_valid_q;
      if (load_q) begin
        sh_out <= spi.rd_data;
      end else if (sclk_fall && state == bws_pkg::BWS_F_DATA && cnt != `BWS_CMD_BITS) begin
        // the fall right after the last command bit must not shift bit 15 away
        sh_out <= {sh_out[14:0], 1'b0};
      end
      if (csn_rise) begin
        // only a whole frame commits; short or long frames are dropped
        done_q <= (state == bws_pkg::BWS_F_DATA) && (cnt == `BWS_FRAME_BITS);
        state  <= bws_pkg::BWS_F_IDLE;
      end else begin
        case (state)
          bws_pkg::BWS_F_IDLE: begin
            if (csn_fall) begin
              state  <= bws_pkg::BWS_F_CMD;
              cnt    <= 5'h00;
              sh_out <= 16'h0000;
            end
          end
          bws_pkg::BWS_F_CMD: begin
            if (sclk_rise) begin
              sh_in <= {sh_in[6:0], mosi_q[1]};
              cnt   <= cnt + 5'h01;
              if (last_cmd) begin
                state        <= bws_pkg::BWS_F_DATA;
                addr_valid_q <= 1'b1;
              end
            end
          end
          bws_pkg::BWS_F_DATA: begin
            if (sclk_rise && cnt != 5'h1f) begin
              cnt <= cnt + 5'h01;
            end
          end
          default: state <= bws_pkg::BWS_F_IDLE;
        endcase
      end
    end
  end

  assign spi.addr       = sh_in[6:0];
  assign spi.clr        = sh_in[7];
  assign spi.addr_valid = addr_valid_q;
  assign spi.frame_done = done_q;
  assign o_spi_miso     = sh_out[15];
  assign o_spi_miso_oe  = (state != bws_pkg::BWS_F_IDLE);
endmodule

// File: core/bws_status_regs.sv
`timescale 1ns/1ps
`include "bws_regs.svh"
module bws_status_regs #(
  parameter int unsigned TX_EN_CYC     = `BWS_TX_EN_CYC,
  parameter int unsigned IRQ_PULSE_CYC = `BWS_IRQ_PULSE_CYC
) (
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  // serial port
  input  wire logic                   i_spi_sclk,
  input  wire logic                   i_spi_csn_b,
  input  wire logic                   i_spi_mosi,
  output logic                        o_spi_miso,
  output logic                        o_spi_miso_oe,
  // device and transceiver state
  input  wire bws_pkg::bws_dev_mode_t i_dev_mode,
  input  wire bws_pkg::bws_trx_mode_t i_trx_mode,
  input  wire logic                   i_soft_rst,
  input  wire logic                   i_restart,
  input  wire logic                   i_cyclic_mode,
  input  wire logic                   i_sample_strobe,
  // selective wake
  input  wire logic                   i_sel_wake_enable_req,
  input  wire logic                   i_bus_silent_indication,
  input  wire logic                   i_sw_config_error,
  input  wire logic [5:0]             i_frame_err_count,
  output logic                        o_selective_wake_enable,
  // transceiver faults
  input  wire logic                   i_transceiver_thermal_off,
  input  wire logic                   i_tx_dominant_timeout,
  input  wire logic                   i_bus_dominant_timeout,
  input  wire logic                   i_bus_recessive,
  input  wire logic                   i_txd,
  input  wire logic                   i_transceiver_supply_low,
  output logic                        o_tx_enable,
  // wake sources
  input  wire logic                   i_bus_wake,
  input  wire logic                   i_timer_one_wake,
  input  wire logic                   i_timer_two_wake,
  input  wire logic [4:0]             i_input_wake,
  input  wire logic [4:0]             i_wake_pin,
  // interrupt
  input  wire logic                   i_silence_timeout_irq_mask,
  output logic                        o_irq_out_n
);
  localparam logic [15:0] WK_IMPL = `BWS_WAKE_IMPL;
  localparam logic [15:0] WK_KEEP = `BWS_WAKE_KEEP;
  localparam logic [15:0] TX_LAST = 16'(TX_EN_CYC - 1);
  localparam logic [15:0] IRQ_LEN = 16'(IRQ_PULSE_CYC);

  if (TX_EN_CYC < 1 || TX_EN_CYC > 65535 || IRQ_PULSE_CYC < 2 || IRQ_PULSE_CYC > 65535) begin
    $error("bws_status_regs: cycle counts out of range");
  end

  bws_spi_if spi ();

  bws_spi_frame u_frame (
    .i_sys_clk     (i_sys_clk),
    .i_rst_b       (i_rst_b),
    .i_spi_sclk    (i_spi_sclk),
    .i_spi_csn_b   (i_spi_csn_b),
    .i_spi_mosi    (i_spi_mosi),
    .o_spi_miso    (o_spi_miso),
    .o_spi_miso_oe (o_spi_miso_oe),
    .spi           (spi)
  );

  logic [4:0]             wk_s1;
  logic [4:0]             wk_s2;
  logic                   txd_s1;
  logic                   txd_s2;
  logic                   low_s1;
  logic                   low_s2;
  logic                   sw_en;
  logic                   to_flag;
  logic                   clr_block;
  logic                   selective_wake_sys_error;
  logic [1:0]             fault;
  logic                   uv;
  logic                   txd_act;
  logic                   bus_act;
  logic                   tx_blocked;
  logic [15:0]            tx_cnt;
  logic [15:0]            irq_cnt;
  logic [15:0]            wk;
  logic [4:0]             lvl;
  logic [15:0]            rd_q;
  bws_pkg::bws_dev_mode_t mode_q;

  // pins from outside the clock domain
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {wk_s2, wk_s1}   <= 10'h000;
      {txd_s2, txd_s1} <= 2'h3;
      {low_s2, low_s1} <= 2'h0;
    end else begin
      {wk_s2, wk_s1}   <= {wk_s1, i_wake_pin};
      {txd_s2, txd_s1} <= {txd_s1, i_txd};
      {low_s2, low_s1} <= {low_s1, i_transceiver_supply_low};
    end
  end

  // mode and command decode
  wire mode_irq  = (i_dev_mode == bws_pkg::BWS_M_NORMAL) || (i_dev_mode == bws_pkg::BWS_M_STOP);
  wire mode_live = mode_irq || (i_dev_mode == bws_pkg::BWS_M_INIT)
                   || (i_dev_mode == bws_pkg::BWS_M_RESTART);
  wire fs_entry  = (i_dev_mode == bws_pkg::BWS_M_FAIL_SAFE)
                   && (mode_q != bws_pkg::BWS_M_FAIL_SAFE);
  wire trx_on    = (i_trx_mode == bws_pkg::BWS_T_NORMAL) || (i_trx_mode == bws_pkg::BWS_T_RX_ONLY);
  wire trx_idle  = (i_trx_mode == bws_pkg::BWS_T_WAKE_CAPABLE)
                   || (i_trx_mode == bws_pkg::BWS_T_OFF);
  wire clr_cmd   = spi.frame_done && spi.clr;
  wire clr_bus   = clr_cmd && (spi.addr == `BWS_ADDR_BUS);
  wire clr_wk    = clr_cmd && (spi.addr == `BWS_ADDR_WAKE);

  // selective wake enable and its system error
  wire next_sw_en  = i_sel_wake_enable_req && (sw_en || !selective_wake_sys_error);
  wire selective_wake_sys_error_set  = sw_en && (i_sw_config_error
                     || (i_frame_err_count > `BWS_FRAME_ERR_LIMIT));
  wire next_selective_wake_sys_error = selective_wake_sys_error_set || (selective_wake_sys_error && !clr_bus);

  // silence timeout; set wins over a clear in the same cycle
  wire to_set    = sw_en && i_bus_silent_indication;
  wire to_new    = to_set && !to_flag;
  wire irq_start = to_new && i_silence_timeout_irq_mask && mode_irq;
  wire irq_fall  = (irq_cnt == IRQ_LEN);
  wire to_clr    = clr_bus && !clr_block;
  wire next_to   = to_set || (to_flag && !to_clr);
  wire next_blk  = irq_start || (clr_block && !irq_fall);

  // transceiver faults: highest code wins when several arrive together
  wire [1:0] fault_evt = i_bus_dominant_timeout    ? `BWS_FAULT_BUS_DOM :
                         i_tx_dominant_timeout     ? `BWS_FAULT_TXD_DOM :
                         i_transceiver_thermal_off ? `BWS_FAULT_THERMAL : `BWS_FAULT_NONE;
  wire [1:0] next_fault = (fault_evt != `BWS_FAULT_NONE) ? fault_evt :
                          clr_bus ? `BWS_FAULT_NONE : fault;
  wire uv_det       = low_s2 && trx_on;
  wire next_uv      = uv_det || (uv && !clr_bus);
  wire next_txd_act = i_tx_dominant_timeout || (txd_act && !txd_s2 && !trx_idle);
  wire next_bus_act = i_bus_dominant_timeout
                      || (bus_act && !i_bus_recessive && !trx_idle);
  wire any_fault    = i_transceiver_thermal_off || txd_act || bus_act || uv_det;

  // wake flags and levels
  wire [15:0] wk_set  = {6'h00, i_bus_wake, i_timer_two_wake, i_timer_one_wake,
                         2'h0, i_input_wake};
  wire        lvl_upd = i_cyclic_mode ? i_sample_strobe : mode_live;

  // read words; unused positions are tied low so reserved bits read zero
  wire [15:0] bus_word = {11'h000, to_flag, selective_wake_sys_error, fault, uv};
  wire [15:0] lvl_word = {11'h000, lvl};
  wire [15:0] rd_mux   = (spi.addr == `BWS_ADDR_BUS)   ? bus_word :
                         (spi.addr == `BWS_ADDR_WAKE)  ? wk :
                         (spi.addr == `BWS_ADDR_LEVEL) ? lvl_word : 16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sw_en  <= 1'b0;
      mode_q <= bws_pkg::BWS_M_INIT;
      rd_q   <= 16'h0000;
    end else begin
      sw_en  <= next_sw_en;
      mode_q <= i_dev_mode;
      if (spi.addr_valid) begin
        rd_q <= rd_mux;
      end
    end
  end
  assign spi.rd_data = rd_q;

  // restart keeps every bus status bit; soft reset clears them
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {to_flag, selective_wake_sys_error, fault, uv} <= 5'(`BWS_BUS_RESET);
      clr_block <= 1'b0;
    end else if (i_soft_rst) begin
      {to_flag, selective_wake_sys_error, fault, uv} <= 5'(`BWS_BUS_RESET);
      clr_block <= 1'b0;
    end else begin
      to_flag   <= next_to;
      selective_wake_sys_error    <= next_selective_wake_sys_error;
      fault     <= next_fault;
      uv        <= next_uv;
      clr_block <= next_blk;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_cnt <= 16'h0000;
    end else if (irq_start) begin
      irq_cnt <= IRQ_LEN;
    end else if (irq_cnt != 16'h0000) begin
      irq_cnt <= irq_cnt - 16'h0001;
    end
  end
  assign o_irq_out_n = (irq_cnt == 16'h0000);

  // after a fault clears, tx data must stay high for a full enable time
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      txd_act    <= 1'b0;
      bus_act    <= 1'b0;
      tx_blocked <= 1'b0;
      tx_cnt     <= 16'h0000;
    end else begin
      txd_act <= next_txd_act;
      bus_act <= next_bus_act;
      if (any_fault) begin
        tx_blocked <= 1'b1;
        tx_cnt     <= 16'h0000;
      end else if (tx_blocked) begin
        if (!txd_s2) begin
          tx_cnt <= 16'h0000;
        end else if (tx_cnt == TX_LAST) begin
          tx_blocked <= 1'b0;
        end else begin
          tx_cnt <= tx_cnt + 16'h0001;
        end
      end
    end
  end
  assign o_tx_enable             = !tx_blocked && !any_fault;
  assign o_selective_wake_enable = sw_en;

  // fail-safe entry is a hardware clear and beats a simultaneous wake event
  for (genvar i = 0; i < 16; i++) begin : g_wk
    if (WK_IMPL[i]) begin : g_bit
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          wk[i] <= 1'b0;
        end else if (i_soft_rst || fs_entry || (i_restart && !WK_KEEP[i])) begin
          wk[i] <= 1'b0;
        end else begin
          wk[i] <= wk_set[i] || (wk[i] && !clr_wk);
        end
      end
    end else begin : g_res
      assign wk[i] = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl <= 5'(`BWS_LEVEL_RESET);
    end else if (i_soft_rst) begin
      lvl <= 5'(`BWS_LEVEL_RESET);
    end else if (lvl_upd) begin
      lvl <= wk_s2;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  AST_TO_NEEDS_ENABLE: assert property ($rose(to_flag) |-> $past(sw_en) || $past(i_soft_rst))
    else $error("timeout flag set while selective wake disabled");
  AST_TO_SET_HOLD: assert property (to_set && !i_soft_rst |=> to_flag ##1 (to_flag || $past(to_clr)))
    else $error("timeout flag not set or not held");
  AST_IRQ_PULSE: assert property (irq_start |=> !o_irq_out_n [*2])
    else $error("interrupt pulse missing after timeout");
  AST_CLR_BLOCKED: assert property (to_flag && clr_block && clr_bus && !i_soft_rst |=> to_flag)
    else $error("timeout flag cleared before interrupt falling edge");
  AST_SELECTIVE_WAKE_SYS_ERROR_SET: assert property (selective_wake_sys_error_set && !i_soft_rst |=> selective_wake_sys_error [*2] or (selective_wake_sys_error ##1 $past(clr_bus)))
    else $error("system error not set");
  AST_NO_ENABLE: assert property (selective_wake_sys_error && !sw_en |=> !sw_en)
    else $error("selective wake enabled while system error set");
  AST_UV_TX_OFF: assert property (uv_det |-> !o_tx_enable ##1 (uv || $past(i_soft_rst)))
    else $error("transmitter on during supply low");
  AST_TX_WAIT: assert property ($fell(any_fault) |-> !o_tx_enable [*2])
    else $error("transmitter resumed without enable time");
  AST_FS_CLEAR: assert property (fs_entry |=> wk == 16'h0000)
    else $error("wake flags not cleared at fail-safe entry");
  AST_LEVEL_TRACK: assert property (lvl_upd && !i_soft_rst |=> lvl == $past(wk_s2))
    else $error("level register not refreshed");
  AST_RESERVED_ZERO: assert property (rd_mux[15:10] == 6'h00 && bus_word[15:5] == 11'h000)
    else $error("reserved bits read nonzero");
endmodule

// File: sim/bws_host_model.sv
`timescale 1ns/1ps
module bws_host_model (
  // clock
  input  wire logic i_sys_clk,
  // serial pins
  input  wire logic i_spi_miso,
  output logic      o_spi_sclk,
  output logic      o_spi_csn_b,
  output logic      o_spi_mosi
);
  initial begin
    o_spi_sclk  = 1'b0;
    o_spi_csn_b = 1'b1;
    o_spi_mosi  = 1'b0;
  end
  // one 24-bit frame, 160 ns a bit; sclk rests low outside frames
  task automatic xfer(input logic clr, input logic [6:0] addr, output logic [15:0] rd);
    logic [7:0] cmd;
    cmd = {clr, addr};
    rd  = 16'h0000;
    @(posedge i_sys_clk);
    o_spi_csn_b <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    for (int i = 23; i >= 0; i--) begin
      // data phase is ignored by the device, so toggle instead of holding a stale level
      o_spi_mosi <= (i > 15) ? cmd[i - 16] : ~o_spi_mosi;
      repeat (8) @(posedge i_sys_clk);
      o_spi_sclk <= 1'b1;
      if (i < 16) begin
        rd[i] = i_spi_miso;
      end
      repeat (8) @(posedge i_sys_clk);
      o_spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge i_sys_clk);
    o_spi_csn_b <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
  endtask
endmodule

// File: sim/bws_status_regs_bench.sv
`timescale 1ns/1ps
`include "bws_regs.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin failures++; $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module bws_status_regs_bench;
  logic                  clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  sclk, csn_b, mosi, miso, oe, swe, txe, irq_n;
  bws_pkg::bws_dev_mode_t mode = bws_pkg::BWS_M_NORMAL;
  bws_pkg::bws_trx_mode_t trx = bws_pkg::BWS_T_NORMAL;
  logic                  srst = 1'b0, rstrt = 1'b0, cyc = 1'b0, strb = 1'b0, req = 1'b0;
  logic                  sil = 1'b0, cfg = 1'b0, hot = 1'b0, txdom = 1'b0, busdom = 1'b0;
  logic                  rec = 1'b1, txd = 1'b1, low = 1'b0, bw = 1'b0, t1 = 1'b0, t2 = 1'b0;
  logic                  mask = 1'b1;
  logic [5:0]            ferr = 6'h00;
  logic [4:0]            iw = 5'h00, pin = 5'h00;
  int                    failures = 0, compares = 0, n;
  always #5 clk = ~clk;
  bws_host_model i_bws_host_model (.i_sys_clk(clk), .i_spi_miso(miso), .o_spi_sclk(sclk),
    .o_spi_csn_b(csn_b), .o_spi_mosi(mosi));
  bws_status_regs #(.TX_EN_CYC(4), .IRQ_PULSE_CYC(2)) i_bws_status_regs (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_spi_sclk(sclk), .i_spi_csn_b(csn_b),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(oe), .i_dev_mode(mode),
    .i_trx_mode(trx), .i_soft_rst(srst), .i_restart(rstrt), .i_cyclic_mode(cyc),
    .i_sample_strobe(strb), .i_sel_wake_enable_req(req), .i_bus_silent_indication(sil),
    .i_sw_config_error(cfg), .i_frame_err_count(ferr), .o_selective_wake_enable(swe),
    .i_transceiver_thermal_off(hot), .i_tx_dominant_timeout(txdom),
    .i_bus_dominant_timeout(busdom), .i_bus_recessive(rec), .i_txd(txd),
    .i_transceiver_supply_low(low), .o_tx_enable(txe), .i_bus_wake(bw),
    .i_timer_one_wake(t1), .i_timer_two_wake(t2), .i_input_wake(iw), .i_wake_pin(pin),
    .i_silence_timeout_irq_mask(mask), .o_irq_out_n(irq_n));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] ex, input string nm);
    logic [15:0] v;
    i_bws_host_model.xfer(1'b0, a, v);
    `CHK(nm, ex, v)
  endtask
  task automatic clr(input logic [6:0] a);
    logic [15:0] v;
    i_bws_host_model.xfer(1'b1, a, v);
  endtask
  // irq is a short pulse, so count low cycles over a fixed span
  task automatic irq_cnt(output int c);
    c = 0;
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      if (irq_n === 1'b0) c++;
    end
  endtask
  task automatic wakes;
    tick(1);
    {bw, t1, t2, iw} <= 8'hff;
    tick(1);
    {bw, t1, t2, iw} <= 8'h00;
    tick(4);
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    tick(4);
    rst_b <= 1'b1;
    tick(4);
    rd(`BWS_ADDR_BUS, 16'h0000, "bus_rst");
    rd(`BWS_ADDR_WAKE, 16'h0000, "wake_rst");
    rd(7'h46, 16'h0000, "unmapped");
    // selective wake off: no timeout flag and no irq
    sil <= 1'b1;
    irq_cnt(n);
    `CHK("irq_off", 0, n)
    rd(`BWS_ADDR_BUS, 16'h0000, "to_off");
    cfg <= 1'b1;
    tick(1);
    cfg <= 1'b0;
    sil <= 1'b0;
    rd(`BWS_ADDR_BUS, 16'h0000, "selective_wake_sys_error_off");
    req <= 1'b1;
    ferr <= 6'h20;
    tick(5);
    `CHK("swe_on", 1'b1, swe)
    rd(`BWS_ADDR_BUS, 16'h0000, "ferr_32");
    ferr <= 6'h21;
    tick(5);
    ferr <= 6'h00;
    rd(`BWS_ADDR_BUS, 16'h0008, "ferr_33");
    req <= 1'b0;
    tick(5);
    req <= 1'b1;
    tick(5);
    `CHK("swe_blocked", 1'b0, swe)
    clr(`BWS_ADDR_BUS);
    tick(5);
    `CHK("swe_again", 1'b1, swe)
    cfg <= 1'b1;
    tick(1);
    cfg <= 1'b0;
    rd(`BWS_ADDR_BUS, 16'h0008, "cfg_err");
    clr(`BWS_ADDR_BUS);
    for (int m = 0; m < 2; m++) begin
      mask <= m[0];
      sil <= 1'b1;
      irq_cnt(n);
      `CHK("irq_pulse", 2 * m, n)
      tick(1);
      sil <= 1'b0;
      rd(`BWS_ADDR_BUS, 16'h0010, "to_held");
      clr(`BWS_ADDR_BUS);
      rd(`BWS_ADDR_BUS, 16'h0000, "to_clr");
    end
    // faults: thermal, tx dominant, bus dominant, each recovered its own way
    for (int f = 1; f < 4; f++) begin
      case (f)
        1: hot <= 1'b1;
        2: {txd, txdom} <= 2'b01;
        default: {rec, busdom} <= 2'b01;
      endcase
      tick(1);
      {txdom, busdom} <= 2'b00;
      tick(4);
      @(negedge clk);
      `CHK("txe_fault", 1'b0, txe)
      tick(1);
      {hot, txd, rec} <= 3'b011;
      tick(2);
      @(negedge clk);
      `CHK("txe_wait", 1'b0, txe)
      tick(12);
      @(negedge clk);
      `CHK("txe_back", 1'b1, txe)
      rd(`BWS_ADDR_BUS, {13'h0000, f[1:0], 1'b0}, "fault_code");
      clr(`BWS_ADDR_BUS);
    end
    low <= 1'b1;
    tick(6);
    @(negedge clk);
    `CHK("txe_low", 1'b0, txe)
    rd(`BWS_ADDR_BUS, 16'h0001, "supply_low");
    low <= 1'b0;
    tick(12);
    @(negedge clk);
    `CHK("txe_supply", 1'b1, txe)
    tick(1);
    clr(`BWS_ADDR_BUS);
    trx <= bws_pkg::BWS_T_OFF;
    low <= 1'b1;
    tick(6);
    rd(`BWS_ADDR_BUS, 16'h0000, "cmp_off");
    {trx, low} <= {bws_pkg::BWS_T_NORMAL, 1'b0};
    // wake flags: latch, host clear, fail-safe clear, restart, soft reset
    wakes();
    rd(`BWS_ADDR_WAKE, `BWS_WAKE_IMPL, "wake_set");
    clr(`BWS_ADDR_WAKE);
    rd(`BWS_ADDR_WAKE, 16'h0000, "wake_clr");
    wakes();
    mode <= bws_pkg::BWS_M_FAIL_SAFE;
    tick(3);
    mode <= bws_pkg::BWS_M_NORMAL;
    rd(`BWS_ADDR_WAKE, 16'h0000, "fail_safe");
    wakes();
    rstrt <= 1'b1;
    tick(1);
    rstrt <= 1'b0;
    rd(`BWS_ADDR_WAKE, `BWS_WAKE_IMPL & `BWS_WAKE_KEEP, "restart");
    srst <= 1'b1;
    tick(1);
    srst <= 1'b0;
    rd(`BWS_ADDR_WAKE, 16'h0000, "soft_rst");
    // levels follow pins in every refreshing mode
    for (int k = 0; k < 4; k++) begin
      mode <= bws_pkg::bws_dev_mode_t'((k == 3) ? 4 : k);
      pin <= 5'(k * 7 + 3);
      tick(5);
      rd(`BWS_ADDR_LEVEL, 16'(k * 7 + 3), "level");
    end
    cyc <= 1'b1;
    pin <= 5'h0a;
    tick(5);
    rd(`BWS_ADDR_LEVEL, 16'h0018, "level_hold");
    strb <= 1'b1;
    tick(1);
    strb <= 1'b0;
    rd(`BWS_ADDR_LEVEL, 16'h000a, "level_sample");
    test_done();
  end
endmodule
